// ==== ubch_top.sv ====
`timescale 1ns/1ps
module ubch_top #(
	parameter int unsigned SHOW_GAP_CYC = ubch_pkg::SHOW_GAP_CYC,
	parameter int          FIFO_DEPTH   = 8,
	parameter int          DIV_W        = 16,
	parameter int          BASE_DIV     = 1
) (
	input  wire logic        sys_clk_in,
	input  wire logic        rst_b_in,
	input  wire logic        serial_rx_in,
	input  wire logic        oscillator_input_in,
	input  wire logic        cts_b_in,
	input  wire logic        config_apply_button_in,
	input  wire logic        first_code_button_in,
	input  wire logic        second_code_button_in,
	input  wire logic [19:0] dip_switch_in,
	input  wire logic [15:0] temp_data_in,
	output logic             serial_tx_out,
	output logic             rts_b_out,
	output logic             cts_indicator_lamp_out,
	output logic             irq_b_out,
	output logic      [7:0]  display_char_out,
	output logic             display_strobe_out,
	output logic             rx_overrun_out,
	output logic      [15:0] cfg_word_out
);
	ubch_pkg::ubch_cfg_t   cfg;
	ubch_pkg::ubch_state_t state;
	logic        tick16;
	logic        rts_bit;
	logic        parity_val;
	// Receiver
	logic        rx_busy;
	logic [3:0]  rx_sub;
	logic [3:0]  rx_idx;
	logic [8:0]  rx_sh;
	logic        rx_push;
	logic [7:0]  rx_byte;
	logic        fifo_in_ready;
	logic        fifo_valid;
	logic [7:0]  fifo_data;
	// Transmitter
	logic        tx_busy;
	logic [3:0]  tx_sub;
	logic [3:0]  tx_left;
	logic [11:0] tx_sh;
	// Command handler
	logic [7:0]  msg_buf [ubch_pkg::MSG_MAX];
	logic [5:0]  msg_cnt;
	logic [5:0]  show_idx;
	logic [31:0] gap_cnt;
	logic [7:0]  rsp [3];
	logic [1:0]  rsp_len;
	logic [1:0]  rsp_idx;
	logic        apply_prev;
	logic        first_prev;
	logic        second_prev;
	logic        first_pend;
	logic        second_pend;

	assign cfg = ubch_pkg::ubch_cfg_t'(cfg_word_out[13:0]);

	ubch_baud_gen #(
		.DIV_W    (DIV_W),
		.BASE_DIV (BASE_DIV)
	) u_baud (
		.sys_clk_in           (sys_clk_in),
		.rst_b_in             (rst_b_in),
		.oscillator_input_in  (oscillator_input_in),
		.baud_divisor_code_in (cfg.baud_divisor_code),
		.tick16_out           (tick16)
	);

	// Receive framing
	wire [3:0] n_data   = cfg.len7 ? 4'd7 : 4'd8;
	wire [3:0] rx_last  = n_data + 4'(cfg.parity_en) + 4'd1;
	wire       rx_mid   = rx_busy && tick16 && (rx_sub == ubch_pkg::OVS_MID);
	wire       rx_start = !rx_busy && tick16 && !serial_rx_in;
	wire       rx_dbit  = rx_mid && (rx_idx != 4'd0) && (rx_idx <= n_data);
	wire       rx_stop  = rx_mid && (rx_idx == rx_last);
	wire       false_st = rx_mid && (rx_idx == 4'd0) && serial_rx_in;

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rx_busy <= 1'b0;
			rx_sub  <= '0;
			rx_idx  <= '0;
			rx_sh   <= '0;
		end else begin
			if (rx_start) begin
				rx_busy <= 1'b1;
				rx_sub  <= '0;
				rx_idx  <= '0;
			end else if (rx_busy && tick16) begin
				rx_sub <= rx_sub + 1'b1;
				if (rx_sub == ubch_pkg::OVS_LAST)
					rx_idx <= rx_idx + 1'b1;
			end
			if (rx_stop || false_st)
				rx_busy <= 1'b0;
			if (rx_dbit)
				rx_sh <= {serial_rx_in, rx_sh[8:1]};
		end
	end

	assign rx_push = rx_stop;
	assign rx_byte = cfg.len7 ? {1'b0, rx_sh[8:2]} : rx_sh[8:1];

	// Drained whenever the handler is listening
	wire take = fifo_valid && (state == ubch_pkg::ST_IDLE || state == ubch_pkg::ST_MSG);

	ubch_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.sys_clk_in    (sys_clk_in),
		.rst_b_in      (rst_b_in),
		.in_valid_in   (rx_push),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    (rx_byte),
		.out_valid_out (fifo_valid),
		.out_ready_in  (take),
		.out_data_out  (fifo_data)
	);

	// Transmit framing: unused high positions stay at stop level
	wire       p_bit     = cfg.parity_en ? parity_val : 1'b1;
	wire [7:0] tx_byte   = rsp[rsp_idx];
	wire [11:0] frame    = cfg.len7 ? {3'h7, p_bit, tx_byte[6:0], 1'b0}
	                                : {2'h3, p_bit, tx_byte, 1'b0};
	wire [3:0] tx_bits   = 4'd2 + n_data + 4'(cfg.parity_en) + 4'(cfg.two_stop);
	wire       tx_start  = (state == ubch_pkg::ST_SEND) && !tx_busy && tick16 && (rsp_idx < rsp_len);
	wire       tx_shift  = tx_busy && tick16 && (tx_sub == ubch_pkg::OVS_LAST);

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tx_busy       <= 1'b0;
			tx_sub        <= '0;
			tx_left       <= '0;
			tx_sh         <= 12'hfff;
			serial_tx_out <= 1'b1;
		end else if (tx_start) begin
			tx_busy       <= 1'b1;
			tx_sub        <= '0;
			tx_left       <= tx_bits;
			tx_sh         <= frame;
			serial_tx_out <= frame[0];
		end else if (tx_busy && tick16) begin
			tx_sub <= tx_sub + 1'b1;
			if (tx_shift) begin
				tx_sh         <= {1'b1, tx_sh[11:1]};
				serial_tx_out <= tx_sh[1];
				tx_left       <= tx_left - 1'b1;
				if (tx_left == 4'd1) begin
					tx_busy       <= 1'b0;
					serial_tx_out <= 1'b1;
				end
			end
		end
	end

	// Buttons and configuration
	wire apply_press  = config_apply_button_in && !apply_prev;
	wire first_press  = first_code_button_in && !first_prev;
	wire second_press = second_code_button_in && !second_prev;
	wire [15:0] sw_cfg_word = {ubch_pkg::CFG_WR_HDR, 1'b0,
	                           dip_switch_in[ubch_pkg::SW_SHDN], 4'h0,
	                           dip_switch_in[ubch_pkg::SW_IR],
	                           dip_switch_in[ubch_pkg::SW_ST],
	                           dip_switch_in[ubch_pkg::SW_PE],
	                           dip_switch_in[ubch_pkg::SW_LEN],
	                           dip_switch_in[ubch_pkg::SW_BAUD +: 4]};
	wire       idle_free = (state == ubch_pkg::ST_IDLE) && !take;

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			apply_prev             <= 1'b0;
			first_prev             <= 1'b0;
			second_prev            <= 1'b0;
			cfg_word_out           <= ubch_pkg::CFG_WORD_RST;
			rts_bit                <= 1'b0;
			parity_val             <= 1'b0;
			rts_b_out              <= 1'b1;
			cts_indicator_lamp_out <= 1'b0;
			irq_b_out              <= 1'b1;
			rx_overrun_out         <= 1'b0;
		end else begin
			apply_prev  <= config_apply_button_in;
			first_prev  <= first_code_button_in;
			second_prev <= second_code_button_in;
			if (apply_press) begin
				cfg_word_out <= sw_cfg_word;
				rts_bit      <= dip_switch_in[ubch_pkg::SW_RTS];
				parity_val   <= dip_switch_in[ubch_pkg::SW_PT];
			end
			rts_b_out              <= ~rts_bit;
			cts_indicator_lamp_out <= ~cts_b_in;
			irq_b_out              <= ~fifo_valid;
			if (rx_push && !fifo_in_ready)
				rx_overrun_out <= 1'b1;
		end
	end

	// Pending code sends; a new press wins over the clear
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			first_pend  <= 1'b0;
			second_pend <= 1'b0;
		end else begin
			first_pend  <= first_press || (first_pend && !idle_free);
			second_pend <= second_press || (second_pend && !(idle_free && !first_pend));
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (state == ubch_pkg::ST_MSG && take && fifo_data != ubch_pkg::MSG_END
		    && fifo_data != ubch_pkg::MSG_HEAD && msg_cnt < 6'(ubch_pkg::MSG_MAX))
			msg_buf[msg_cnt] <= fifo_data;
	end

	// Command handler
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state              <= ubch_pkg::ST_IDLE;
			msg_cnt            <= '0;
			show_idx           <= '0;
			gap_cnt            <= '0;
			rsp[0]             <= '0;
			rsp[1]             <= '0;
			rsp[2]             <= '0;
			rsp_len            <= '0;
			rsp_idx            <= '0;
			display_char_out   <= '0;
			display_strobe_out <= 1'b0;
		end else begin
			display_strobe_out <= 1'b0;
			case (state)
				ubch_pkg::ST_IDLE: begin
					rsp_idx <= '0;
					if (take) begin
						case (fifo_data)
							ubch_pkg::MSG_HEAD: begin
								msg_cnt <= '0;
								state   <= ubch_pkg::ST_MSG;
							end
							ubch_pkg::CMD_TEMP: begin
								rsp[0]  <= temp_data_in[15:8];
								rsp[1]  <= temp_data_in[7:0];
								rsp_len <= 2'd2;
								state   <= ubch_pkg::ST_SEND;
							end
							ubch_pkg::CMD_DIP: begin
								rsp[0]  <= {4'h0, dip_switch_in[19:16]};
								rsp[1]  <= dip_switch_in[15:8];
								rsp[2]  <= dip_switch_in[7:0];
								rsp_len <= 2'd3;
								state   <= ubch_pkg::ST_SEND;
							end
							ubch_pkg::CMD_CFG: begin
								rsp[0]  <= {2'h0, cfg_word_out[13:8]};
								rsp[1]  <= cfg_word_out[7:0];
								rsp_len <= 2'd2;
								state   <= ubch_pkg::ST_SEND;
							end
							default: begin
								if (fifo_data >= ubch_pkg::PRINT_MIN) begin
									display_char_out   <= fifo_data;
									display_strobe_out <= 1'b1;
								end
							end
						endcase
					end else if (first_pend || second_pend) begin
						rsp[0]  <= first_pend ? ubch_pkg::CODE_FIRST
						                      : ubch_pkg::CODE_SECND;
						rsp_len <= 2'd1;
						state   <= ubch_pkg::ST_SEND;
					end
				end
				ubch_pkg::ST_MSG: begin
					if (take) begin
						if (fifo_data == ubch_pkg::MSG_END) begin
							show_idx <= '0;
							gap_cnt  <= '0;
							state    <= ubch_pkg::ST_SHOW;
						end else if (fifo_data == ubch_pkg::MSG_HEAD) begin
							msg_cnt <= '0;
						end else if (msg_cnt < 6'(ubch_pkg::MSG_MAX)) begin
							msg_cnt <= msg_cnt + 1'b1;
						end
					end
				end
				ubch_pkg::ST_SHOW: begin
					if (gap_cnt != '0) begin
						gap_cnt <= gap_cnt - 1'b1;
					end else if (show_idx == msg_cnt) begin
						state <= ubch_pkg::ST_IDLE;
					end else begin
						display_char_out   <= msg_buf[show_idx];
						display_strobe_out <= 1'b1;
						show_idx           <= show_idx + 1'b1;
						gap_cnt            <= SHOW_GAP_CYC - 1;
					end
				end
				ubch_pkg::ST_SEND: begin
					if (tx_start)
						rsp_idx <= rsp_idx + 1'b1;
					else if (!tx_busy && rsp_idx == rsp_len)
						state <= ubch_pkg::ST_IDLE;
				end
				default: state <= ubch_pkg::ST_IDLE;
			endcase
		end
	end
endmodule : ubch_top

// ==== ubch_pkg.sv ====
// Notes on behaviour
// - Receiver pulls the active-low interrupt line low while received data waits.
// - A lone received character of 0x20 or above is read out and shown on the display.
// - Receive FIFO is drained on every request while a message arrives.
// - After the end byte, buffered characters are shown about 0.5 s apart.
// - Command 0x03 returns the two temperature bytes to the PC.
// - Command 0x04 returns the DIP-switch states packed into three bytes.
// - First code button sends 0x05, second code button sends 0x06.
// - Apply button rewrites the configuration, baud divisor code included, from switches.
// - Request-to-send output is the inverse of its configuration bit.
// - Clear-to-send lamp is lit while clear-to-send input is low.
// - Four-bit baud divisor code selects the oscillator input divisor.
// - Divided baud clock runs at sixteen times the bit rate.
// - Only transmit and receive lines are needed; handshake lines are optional.
// - Board reset returns controller and serial port to power-on state.
// - Command 0x07 returns the 14 configuration bits as two bytes.
// - Applying switches writes one 16-bit configuration word.
package ubch_pkg;
	localparam logic [7:0] MSG_HEAD   = 8'h01;
	localparam logic [7:0] MSG_END    = 8'h02;
	localparam logic [7:0] CMD_TEMP   = 8'h03;
	localparam logic [7:0] CMD_DIP    = 8'h04;
	localparam logic [7:0] CODE_FIRST = 8'h05;
	localparam logic [7:0] CODE_SECND = 8'h06;
	localparam logic [7:0] CMD_CFG    = 8'h07;
	localparam logic [7:0] PRINT_MIN  = 8'h20;
	localparam int         MSG_MAX    = 50;
	localparam logic [3:0] OVS_MID    = 4'h7;
	localparam logic [3:0] OVS_LAST   = 4'hf;
	localparam int         CLK_MHZ    = 200;
	localparam int         SHOW_GAP_MS = 500;
	localparam int unsigned SHOW_GAP_CYC = SHOW_GAP_MS * CLK_MHZ * 1000;
	localparam logic [1:0] CFG_WR_HDR = 2'h3;
	// Switch bit positions: bank one at 0..7, bank two at 8..19
	localparam int SW_SHDN = 1;
	localparam int SW_IR   = 6;
	localparam int SW_ST   = 7;
	localparam int SW_PE   = 8;
	localparam int SW_LEN  = 9;
	localparam int SW_BAUD = 11;
	localparam int SW_RTS  = 17;
	localparam int SW_PT   = 18;
	localparam logic [15:0] CFG_WORD_RST = 16'h0000;

	typedef struct packed {
		logic       fen;
		logic       shdn_i;
		logic [3:0] irq_masks;
		logic       ir;
		logic       two_stop;
		logic       parity_en;
		logic       len7;
		logic [3:0] baud_divisor_code;
	} ubch_cfg_t;

	typedef enum logic [1:0] {ST_IDLE, ST_MSG, ST_SHOW, ST_SEND} ubch_state_t;
endpackage : ubch_pkg

// ==== ubch_fifo.sv ====
`timescale 1ns/1ps
module ubch_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             sys_clk_in,
	input  wire logic             rst_b_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	wire              push = in_valid_in && in_ready_out;
	wire              pop  = out_valid_out && out_ready_in;

	assign in_ready_out  = (count != (AW+1)'(DEPTH));
	assign out_valid_out = (count != '0);
	assign out_data_out  = mem[rd_ptr];

	always_ff @(posedge sys_clk_in) begin
		if (push)
			mem[wr_ptr] <= in_data_in;
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : ubch_fifo

// ==== ubch_baud_gen.sv ====
`timescale 1ns/1ps
module ubch_baud_gen #(
	parameter int DIV_W    = 16,
	parameter int BASE_DIV = 1
) (
	input  wire logic       sys_clk_in,
	input  wire logic       rst_b_in,
	input  wire logic       oscillator_input_in,
	input  wire logic [3:0] baud_divisor_code_in,
	output logic            tick16_out
);
	logic             osc_prev;
	logic [DIV_W-1:0] div_cnt;
	wire              osc_rise = oscillator_input_in && !osc_prev;
	wire [DIV_W-1:0]  baud_rate_divisor = DIV_W'(BASE_DIV) << baud_divisor_code_in;
	wire              wrap = (div_cnt >= baud_rate_divisor - 1'b1);

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			osc_prev   <= 1'b0;
			div_cnt    <= '0;
			tick16_out <= 1'b0;
		end else begin
			osc_prev   <= oscillator_input_in;
			tick16_out <= osc_rise && wrap;
			if (osc_rise)
				div_cnt <= wrap ? '0 : div_cnt + 1'b1;
		end
	end
endmodule : ubch_baud_gen

// ==== ubch_pc_model.sv ====
`timescale 1ns/1ps
module ubch_pc_model #(
	parameter int BIT_CYC = 32
) (
	input  wire logic sys_clk_in,
	input  wire logic line_from_dut_in,
	output logic      line_to_dut_out
);
	logic [7:0] rx_q[$];
	logic [7:0] sh;

	initial line_to_dut_out = 1'h1;

	task automatic wait_bits(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask : wait_bits

	// No parity, one stop; 7 or 8 data bits
	task automatic send(input logic [7:0] b, input int nb = 8);
		line_to_dut_out = 1'h0;
		wait_bits(BIT_CYC);
		for (int i = 0; i < nb; i++) begin
			line_to_dut_out = b[i];
			wait_bits(BIT_CYC);
		end
		line_to_dut_out = 1'h1;
		wait_bits(BIT_CYC);
	endtask : send

	always begin
		@(negedge line_from_dut_in);
		wait_bits(BIT_CYC / 2);
		for (int i = 0; i < 8; i++) begin
			wait_bits(BIT_CYC);
			sh[i] = line_from_dut_in;
		end
		rx_q.push_back(sh);
	end
endmodule : ubch_pc_model

// ==== ubch_top_asserts.sv ====
`timescale 1ns/1ps
module ubch_top_asserts (
	input wire logic        sys_clk_in,
	input wire logic        rst_b_in,
	input wire logic        cts_b_in,
	input wire logic        config_apply_button_in,
	input wire logic [19:0] dip_switch_in,
	input wire logic        serial_tx_out,
	input wire logic        rts_b_out,
	input wire logic        cts_indicator_lamp_out,
	input wire logic [7:0]  display_char_out,
	input wire logic        display_strobe_out,
	input wire logic        rx_overrun_out,
	input wire logic [15:0] cfg_word_out
);
	logic [1:0]  settle;
	wire         armed = settle == 2'h3;
	wire  [15:0] cfg_exp = {3'h6, dip_switch_in[1], 4'h0, dip_switch_in[6], dip_switch_in[7],
		dip_switch_in[8], dip_switch_in[9], dip_switch_in[14:11]};

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			settle <= 2'h0;
		else if (!armed)
			settle <= settle + 2'h1;
	end

	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence s_apply;
		$rose(config_apply_button_in);
	endsequence

	a_cfg_apply: assert property (
		s_apply |=> cfg_word_out == $past(cfg_exp)) else $error("config word wrong");
	a_cfg_hold: assert property (
		armed && !$rose(config_apply_button_in) |=> $stable(cfg_word_out))
		else $error("config word changed");
	a_rts_inverted: assert property (
		s_apply |-> ##2 rts_b_out == !$past(dip_switch_in[17], 2)) else $error("rts wrong");
	a_rts_hold: assert property (
		armed && $changed(rts_b_out) |-> $past(config_apply_button_in, 2)
		&& !$past(config_apply_button_in, 3)) else $error("rts moved");
	a_lamp_follows: assert property (
		armed |-> cts_indicator_lamp_out == !$past(cts_b_in)) else $error("lamp wrong");
	a_strobe_change: assert property (
		armed && $changed(display_char_out) |-> display_strobe_out) else $error("no strobe");
	a_overrun_sticky: assert property (
		rx_overrun_out |=> rx_overrun_out) else $error("overrun cleared");
	a_tx_start_hold: assert property (
		$fell(serial_tx_out) |=> !serial_tx_out [*8]) else $error("start bit short");
endmodule : ubch_top_asserts

bind ubch_top ubch_top_asserts u_chk (.sys_clk_in, .rst_b_in, .cts_b_in, .config_apply_button_in,
	.dip_switch_in, .serial_tx_out, .rts_b_out, .cts_indicator_lamp_out, .display_char_out,
	.display_strobe_out, .rx_overrun_out, .cfg_word_out);

// ==== tb.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("wrong value at %0t: %h expected %h", $time, g, e); end end
module tb;
	localparam int GAP = 4000;
	logic        sys_clk_in, rst_b_in, cts_b, apply_btn, first_btn, second_btn;
	logic        osc = 1'h0;
	logic        txd, rts_b, lamp, irq_b, strobe, ovr, irq_seen;
	logic [19:0] dip;
	logic [15:0] temp, cfg;
	logic [7:0]  disp;
	logic [7:0]  st_chr[$];
	int          st_cyc[$];
	int          fail_count, num_checks, n, cyc;
	wire         rxd;

	ubch_top #(.SHOW_GAP_CYC(GAP)) dut (.sys_clk_in, .rst_b_in, .serial_rx_in(rxd),
		.oscillator_input_in(osc), .cts_b_in(cts_b), .config_apply_button_in(apply_btn),
		.first_code_button_in(first_btn), .second_code_button_in(second_btn),
		.dip_switch_in(dip), .temp_data_in(temp), .serial_tx_out(txd), .rts_b_out(rts_b),
		.cts_indicator_lamp_out(lamp), .irq_b_out(irq_b), .display_char_out(disp),
		.display_strobe_out(strobe), .rx_overrun_out(ovr), .cfg_word_out(cfg));
	ubch_pc_model pc (.sys_clk_in, .line_from_dut_in(txd), .line_to_dut_out(rxd));

	initial begin
		sys_clk_in = 1'h0;
		forever #2.5 sys_clk_in = ~sys_clk_in;
	end

	always @(posedge sys_clk_in) begin
		osc <= ~osc;
		cyc++;
		if (strobe === 1'h1) begin
			st_cyc.push_back(cyc);
			st_chr.push_back(disp);
		end
		if (irq_b === 1'h0)
			irq_seen = 1'h1;
	end

	task automatic step(input int k);
		repeat (k) @(posedge sys_clk_in);
		#1;
	endtask : step

	task automatic do_reset;
		rst_b_in = 1'h0;
		step(16);
		rst_b_in = 1'h1;
		step(2);
	endtask : do_reset

	task automatic press_apply;
		apply_btn = 1'h1;
		step(3);
		apply_btn = 1'h0;
		step(1);
	endtask : press_apply

	task automatic wait_q(input int cnt);
		n = 0;
		while (pc.rx_q.size() < cnt && n < 3000) begin
			step(1);
			n++;
		end
		step(400);
		`CHK(pc.rx_q.size(), cnt)
	endtask : wait_q

	task automatic t_cmd(input logic [7:0] cmd, input int cnt, input logic [23:0] exp);
		pc.rx_q.delete();
		pc.send(cmd);
		wait_q(cnt);
		for (int i = 0; i < cnt; i++)
			`CHK(pc.rx_q[i], exp[8*(cnt-1-i) +: 8])
	endtask : t_cmd

	task automatic t_reset;
		`CHK({txd, rts_b, lamp, irq_b, ovr}, 5'h1a)
		`CHK({disp, cfg}, 24'h000000)
	endtask : t_reset

	task automatic t_lamp;
		cts_b = 1'h0;
		step(2);
		`CHK(lamp, 1'h1)
		cts_b = 1'h1;
		step(2);
		`CHK(lamp, 1'h0)
	endtask : t_lamp

	task automatic t_lone;
		st_chr.delete();
		irq_seen = 1'h0;
		pc.send(8'h41);
		step(10);
		`CHK(st_chr[0], 8'h41)
		`CHK({irq_seen, irq_b}, 2'h3)
	endtask : t_lone

	task automatic t_buttons;
		pc.rx_q.delete();
		first_btn = 1'h1;
		step(2);
		first_btn = 1'h0;
		second_btn = 1'h1;
		step(2);
		second_btn = 1'h0;
		wait_q(2);
		`CHK({pc.rx_q[0], pc.rx_q[1]}, 16'h0506)
	endtask : t_buttons

	task automatic t_apply;
		dip = 20'h00080;
		press_apply();
		`CHK(cfg, 16'hc040)
		`CHK(rts_b, 1'h1)
		t_cmd(8'h07, 2, 24'h000040);
	endtask : t_apply

	task automatic t_msg;
		logic [7:0] msg[4] = '{8'h01, 8'h41, 8'h42, 8'h02};
		st_chr.delete();
		st_cyc.delete();
		foreach (msg[i])
			pc.send(msg[i]);
		repeat (9) pc.send(8'h10);
		`CHK({ovr, irq_b}, 2'h2)
		step(3 * GAP);
		`CHK({st_chr[0], st_chr[1]}, 16'h4142)
		`CHK(st_cyc[1] - st_cyc[0], GAP)
		`CHK(st_chr.size(), 2)
		`CHK(irq_b, 1'h1)
	endtask : t_msg

	task automatic t_len7;
		dip = 20'h00200;
		press_apply();
		`CHK(cfg, 16'hc010)
		st_chr.delete();
		pc.send(8'h43, 7);
		step(10);
		`CHK(st_chr[0], 8'h43)
		pc.rx_q.delete();
		pc.send(8'h07, 7);
		wait_q(2);
		`CHK({pc.rx_q[0], pc.rx_q[1]}, 16'h8090)
	endtask : t_len7

	task automatic t_baud;
		dip = 20'h20800;
		press_apply();
		`CHK(cfg, 16'hc001)
		`CHK(rts_b, 1'h0)
		first_btn = 1'h1;
		step(2);
		first_btn = 1'h0;
		n = 0;
		while (txd !== 1'h0 && n < 500) begin
			step(1);
			n++;
		end
		n = 0;
		while (txd === 1'h0 && n < 500) begin
			step(1);
			n++;
		end
		`CHK(n, 64)
	endtask : t_baud

	task automatic complete_run;
		$display("checks %0d, errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	initial begin
		#400000;
		fail_count++;
		complete_run();
	end

	initial begin
		{rst_b_in, cts_b, apply_btn, first_btn, second_btn} = 5'h08;
		dip = 20'h5a3c6;
		temp = 16'h1234;
		do_reset();
		t_reset();
		t_lamp();
		t_lone();
		t_cmd(8'h03, 2, 24'h001234);
		t_cmd(8'h04, 3, 24'h05a3c6);
		t_cmd(8'h10, 0, 24'h000000);
		t_buttons();
		t_apply();
		t_msg();
		t_len7();
		do_reset();
		t_reset();
		t_baud();
		complete_run();
	end
endmodule : tb
